// ---- hw/meas_pkg.sv ----
/*
  shared constants of the measurement control block: register offsets,
  field positions, reset values, timing counts and the sequencer states.
  assumes a 20 MHz system clock and an 8-bit register port.
*/
package meas_pkg;

  // register offsets
  localparam logic [7:0] ADDR_X_HIGH = 8'h00;
  localparam logic [7:0] ADDR_X_MID = 8'h01;
  localparam logic [7:0] ADDR_Y_HIGH = 8'h02;
  localparam logic [7:0] ADDR_Y_MID = 8'h03;
  localparam logic [7:0] ADDR_Z_HIGH = 8'h04;
  localparam logic [7:0] ADDR_Z_MID = 8'h05;
  localparam logic [7:0] ADDR_XYZ_LOW = 8'h06;
  localparam logic [7:0] ADDR_TEMP = 8'h07;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CONTROL = 8'h09;

  // status field positions
  localparam int STAT_FIELD_DONE = 0;
  localparam int STAT_TEMP_DONE = 1;
  localparam int STAT_TRIM_OK = 4;

  // control field positions
  localparam int CTL_START_FIELD = 0;
  localparam int CTL_START_TEMP = 1;
  localparam int CTL_INT_EN = 2;
  localparam int CTL_SET_PULSE = 3;
  localparam int CTL_RESET_PULSE = 4;
  localparam int CTL_AUTO_DEGAUSS = 5;
  localparam int CTL_TRIM_RELOAD = 6;

  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // result and counter widths
  localparam int FIELD_W = 18;
  localparam int TEMP_W = 8;
  localparam int CONV_CNT_W = 18;
  localparam int PULSE_CNT_W = 4;

  // clock
  localparam int CLK_PERIOD_NS = 50;

  // least time to cycles, rounded up, never below one
  function automatic int ns_to_cycles(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    ns_to_cycles = (c < 1) ? 1 : c;
  endfunction : ns_to_cycles

  // coil pulse
  localparam int COIL_PULSE_NS = 500;
  localparam int COIL_PULSE_CYC = ns_to_cycles(COIL_PULSE_NS);

  // conversion lengths per length select code, and the temperature conversion length
  localparam int CONV_SEL0_NS = 8000000;
  localparam int CONV_SEL1_NS = 4000000;
  localparam int CONV_SEL2_NS = 2000000;
  localparam int CONV_SEL3_NS = 500000;
  localparam int CONV_TEMP_NS = 2000000;
  localparam int CONV_SEL0_CYC = ns_to_cycles(CONV_SEL0_NS);
  localparam int CONV_SEL1_CYC = ns_to_cycles(CONV_SEL1_NS);
  localparam int CONV_SEL2_CYC = ns_to_cycles(CONV_SEL2_NS);
  localparam int CONV_SEL3_CYC = ns_to_cycles(CONV_SEL3_NS);
  localparam int CONV_TEMP_CYC = ns_to_cycles(CONV_TEMP_NS);

  // sequencer states, gray along idle -> pulse -> field
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PULSE = 3'h1,
    ST_FIELD = 3'h3,
    ST_TEMP = 3'h2,
    ST_TRIM = 3'h6
  } seq_state_t;

endpackage : meas_pkg

// ---- hw/coil_pulse_gen.sv ----
/*
  coil current pulse generator: one fixed-width set or reset pulse per start.
  assumes start arrives only while idle.
*/
`timescale 1ns/1ps
`default_nettype none

module coil_pulse_gen
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // request
  input wire logic start_i,
  input wire logic polarity_i,
  // coil drive
  output logic set_coil_o,
  output logic reset_coil_o,
  output logic done_o
);

  logic [meas_pkg::PULSE_CNT_W-1:0] count;
  logic [meas_pkg::PULSE_CNT_W-1:0] high_len;
  localparam logic [meas_pkg::PULSE_CNT_W-1:0] LAST =
    meas_pkg::PULSE_CNT_W'(meas_pkg::COIL_PULSE_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // pulse width counter; the two coils are never driven together
  always_ff @(posedge sys_clk_i)
  begin
    done_o <= 1'b0;
    if (!resetn_i)
    begin
      count <= '0;
      set_coil_o <= 1'b0;
      reset_coil_o <= 1'b0;
    end
    else if (start_i && !set_coil_o && !reset_coil_o)
    begin
      count <= '0;
      set_coil_o <= !polarity_i;
      reset_coil_o <= polarity_i;
    end
    else if (set_coil_o || reset_coil_o)
    begin
      count <= count + 1'b1;
      if (count == LAST)
      begin
        set_coil_o <= 1'b0;
        reset_coil_o <= 1'b0;
        done_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run length of the coil drive, counted so the checks need no long repeat
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i || !(set_coil_o || reset_coil_o))
      high_len <= '0;
    else
      high_len <= high_len + 1'b1;
  end

  chk_set_width: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    $fell(set_coil_o) |-> high_len == LAST + 1'b1 && done_o)
    else $error("set pulse width wrong");
  chk_reset_width: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    $fell(reset_coil_o) |-> high_len == LAST + 1'b1 && done_o)
    else $error("reset pulse width wrong");

endmodule : coil_pulse_gen

`default_nettype wire

// ---- hw/conv_timer.sv ----
/*
  conversion timer: counts a loaded length, then pulses done.
  assumes start arrives only while idle.
*/
`timescale 1ns/1ps
`default_nettype none

module conv_timer
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // request
  input wire logic start_i,
  input wire logic [meas_pkg::CONV_CNT_W-1:0] length_i,
  // progress
  output logic busy_o,
  output logic done_o
);

  logic [meas_pkg::CONV_CNT_W-1:0] remain;

  ////////////////////////////////////////////////////////////////////////////
  // down counter; length of one counts as a single cycle
  always_ff @(posedge sys_clk_i)
  begin
    done_o <= 1'b0;
    if (!resetn_i)
    begin
      remain <= '0;
      busy_o <= 1'b0;
    end
    else if (start_i && !busy_o)
    begin
      remain <= length_i;
      busy_o <= 1'b1;
    end
    else if (busy_o)
    begin
      remain <= remain - 1'b1;
      if (remain <= 18'h00001)
      begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_done_ends: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    done_o |-> !busy_o && $past(busy_o))
    else $error("done without running conversion");

endmodule : conv_timer

`default_nettype wire

// ---- hw/magnetometer_meas_ctrl_regs.sv ----
/*
  measurement control and result readout of a three-axis field sensor:
  register file, conversion sequencer, coil pulses, trim load, interrupt.
  assumes an 8-bit register port already decoded from the serial link,
  and front-end results valid when their conversion finishes.
*/
// What this block does
// - x result 18 bits: 17..10 at 00, 9..2 at 01, 1..0 at 06[7:6]
// - y result 18 bits: 17..10 at 02, 9..2 at 03, 1..0 at 06[5:4]
// - z result 18 bits at 04, 05, 06[3:2]; 06[1:0] read zero
// - temperature is an 8-bit unsigned code at 07
// - field done flag drops on new command, rises at completion, holds
// - temperature done flag drops on command, rises at completion, holds
// - writing one to a done bit clears its interrupt
// - status bit 4 shows trim memory loaded successfully
// - control bit 0 starts field conversion, self-clears at its end
// - control bit 1 starts temperature conversion, self-clears at end
// - with control bit 2 set, each field or temperature completion raises the interrupt
// - control bit 3 drives a 500 ns set pulse, then self-clears
// - control bit 4 drives a 500 ns reset pulse, then self-clears
// - control bit 5 enables automatic degauss pulse before field measurements
// - control bit 6 reloads trim memory, self-clears when refreshed
// - interrupt active high, undriven until an interrupt is enabled
// - field conversion length from 2-bit select: 8, 4, 2, 0.5 ms
`timescale 1ns/1ps
`default_nettype none

module magnetometer_meas_ctrl_regs
#(
  parameter int unsigned CONV_SEL0_CYC = meas_pkg::CONV_SEL0_CYC,
  parameter int unsigned CONV_SEL1_CYC = meas_pkg::CONV_SEL1_CYC,
  parameter int unsigned CONV_SEL2_CYC = meas_pkg::CONV_SEL2_CYC,
  parameter int unsigned CONV_SEL3_CYC = meas_pkg::CONV_SEL3_CYC,
  parameter int unsigned CONV_TEMP_CYC = meas_pkg::CONV_TEMP_CYC
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // conversion setup
  input wire logic [1:0] conv_length_sel_i,
  // front-end results
  input wire logic [meas_pkg::FIELD_W-1:0] x_field_i,
  input wire logic [meas_pkg::FIELD_W-1:0] y_field_i,
  input wire logic [meas_pkg::FIELD_W-1:0] z_field_i,
  input wire logic [meas_pkg::TEMP_W-1:0] temp_code_i,
  output logic field_conv_o,
  output logic temp_conv_o,
  // coil drive
  output logic set_coil_o,
  output logic reset_coil_o,
  // trim memory
  output logic trim_load_o,
  input wire logic trim_done_i,
  // interrupt pin
  output logic int_o,
  output logic int_oe_o
);

  localparam int FW = meas_pkg::FIELD_W;
  localparam int CW = meas_pkg::CONV_CNT_W;

  meas_pkg::seq_state_t state;
  logic start_field_conv;
  logic start_temp_conv;
  logic int_en;
  logic set_req;
  logic reset_req;
  logic auto_degauss_enable;
  logic trim_reload;
  logic boot_trim;
  logic field_done;
  logic temp_done;
  logic trim_ok;
  logic pend_field;
  logic pend_temp;
  logic [FW-1:0] x_result;
  logic [FW-1:0] y_result;
  logic [FW-1:0] z_result;
  logic [meas_pkg::TEMP_W-1:0] temp_result;
  logic pulse_start;
  logic pulse_polarity;
  logic pulse_done;
  logic pulse_for_field;
  logic conv_start;
  logic [CW-1:0] conv_length;
  logic conv_done;
  logic field_end;
  logic temp_end;
  logic ctl_wr;
  logic stat_wr;
  logic [7:0] next_rdata;

  assign ctl_wr = reg_wr_i && (reg_addr_i == meas_pkg::ADDR_CONTROL);
  assign stat_wr = reg_wr_i && (reg_addr_i == meas_pkg::ADDR_STATUS);
  assign field_end = conv_done && (state == meas_pkg::ST_FIELD);
  assign temp_end = conv_done && (state == meas_pkg::ST_TEMP);

  ////////////////////////////////////////////////////////////////////////////
  // conversion length; field converts all three axes in one run
  always_comb
  begin
    unique case (conv_length_sel_i)
      2'h0: conv_length = CW'(CONV_SEL0_CYC);
      2'h1: conv_length = CW'(CONV_SEL1_CYC);
      2'h2: conv_length = CW'(CONV_SEL2_CYC);
      2'h3: conv_length = CW'(CONV_SEL3_CYC);
    endcase
    if (state == meas_pkg::ST_TEMP)
      conv_length = CW'(CONV_TEMP_CYC);
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer; trim load outranks everything, field outranks temperature
  always_ff @(posedge sys_clk_i)
  begin
    pulse_start <= 1'b0;
    conv_start <= 1'b0;
    trim_load_o <= 1'b0;
    if (!resetn_i)
    begin
      state <= meas_pkg::ST_IDLE;
      pulse_polarity <= 1'b0;
      pulse_for_field <= 1'b0;
    end
    else
    begin
      unique case (state)
        meas_pkg::ST_IDLE:
        begin
          if (boot_trim || trim_reload)
          begin
            state <= meas_pkg::ST_TRIM;
            trim_load_o <= 1'b1;
          end
          else if (start_field_conv && auto_degauss_enable)
          begin
            // degauss first so the bridge starts from a known polarity
            state <= meas_pkg::ST_PULSE;
            pulse_start <= 1'b1;
            pulse_polarity <= 1'b0;
            pulse_for_field <= 1'b1;
          end
          else if (start_field_conv)
          begin
            state <= meas_pkg::ST_FIELD;
            conv_start <= 1'b1;
          end
          else if (start_temp_conv)
          begin
            state <= meas_pkg::ST_TEMP;
            conv_start <= 1'b1;
          end
          else if (set_req || reset_req)
          begin
            state <= meas_pkg::ST_PULSE;
            pulse_start <= 1'b1;
            pulse_polarity <= !set_req;
            pulse_for_field <= 1'b0;
          end
        end
        meas_pkg::ST_PULSE:
        begin
          if (pulse_done && pulse_for_field)
          begin
            state <= meas_pkg::ST_FIELD;
            conv_start <= 1'b1;
          end
          else if (pulse_done)
            state <= meas_pkg::ST_IDLE;
        end
        meas_pkg::ST_FIELD, meas_pkg::ST_TEMP:
        begin
          if (conv_done)
            state <= meas_pkg::ST_IDLE;
        end
        meas_pkg::ST_TRIM:
        begin
          if (trim_done_i)
            state <= meas_pkg::ST_IDLE;
        end
        default: state <= meas_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register; a start written in the ending cycle is kept
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      {trim_reload, auto_degauss_enable, reset_req, set_req} <= 4'h0;
      {int_en, start_temp_conv, start_field_conv} <= 3'h0;
      boot_trim <= 1'b1;
    end
    else
    begin
      if (field_end)
        start_field_conv <= 1'b0;
      if (temp_end)
        start_temp_conv <= 1'b0;
      if (pulse_done && !pulse_for_field && !pulse_polarity)
        set_req <= 1'b0;
      if (pulse_done && !pulse_for_field && pulse_polarity)
        reset_req <= 1'b0;
      if (state == meas_pkg::ST_TRIM && trim_done_i)
      begin
        trim_reload <= 1'b0;
        boot_trim <= 1'b0;
      end
      if (ctl_wr)
      begin
        int_en <= reg_wdata_i[meas_pkg::CTL_INT_EN];
        auto_degauss_enable <= reg_wdata_i[meas_pkg::CTL_AUTO_DEGAUSS];
        if (reg_wdata_i[meas_pkg::CTL_START_FIELD])
          start_field_conv <= 1'b1;
        if (reg_wdata_i[meas_pkg::CTL_START_TEMP])
          start_temp_conv <= 1'b1;
        if (reg_wdata_i[meas_pkg::CTL_SET_PULSE])
          set_req <= 1'b1;
        if (reg_wdata_i[meas_pkg::CTL_RESET_PULSE])
          reset_req <= 1'b1;
        if (reg_wdata_i[meas_pkg::CTL_TRIM_RELOAD])
          trim_reload <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // done flags; completion wins over a command in the same cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      field_done <= 1'b0;
      temp_done <= 1'b0;
      trim_ok <= 1'b0;
    end
    else
    begin
      if (field_end)
        field_done <= 1'b1;
      else if (ctl_wr && reg_wdata_i[meas_pkg::CTL_START_FIELD])
        field_done <= 1'b0;
      if (temp_end)
        temp_done <= 1'b1;
      else if (ctl_wr && reg_wdata_i[meas_pkg::CTL_START_TEMP])
        temp_done <= 1'b0;
      if (state == meas_pkg::ST_TRIM && trim_done_i)
        trim_ok <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // results latched only at completion so reads stay coherent
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      x_result <= '0;
      y_result <= '0;
      z_result <= '0;
      temp_result <= '0;
    end
    else
    begin
      if (field_end)
      begin
        x_result <= x_field_i;
        y_result <= y_field_i;
        z_result <= z_field_i;
      end
      if (temp_end)
        temp_result <= temp_code_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // front-end run strobes follow the conversion window
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      field_conv_o <= 1'b0;
      temp_conv_o <= 1'b0;
    end
    else
    begin
      field_conv_o <= !conv_start && !conv_done && state == meas_pkg::ST_FIELD;
      temp_conv_o <= !conv_start && !conv_done && state == meas_pkg::ST_TEMP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt; pin stays undriven until software first enables it
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      pend_field <= 1'b0;
      pend_temp <= 1'b0;
      int_o <= 1'b0;
      int_oe_o <= 1'b0;
    end
    else
    begin
      if (field_end && int_en)
        pend_field <= 1'b1;
      else if (stat_wr && reg_wdata_i[meas_pkg::STAT_FIELD_DONE])
        pend_field <= 1'b0;
      if (temp_end && int_en)
        pend_temp <= 1'b1;
      else if (stat_wr && reg_wdata_i[meas_pkg::STAT_TEMP_DONE])
        pend_temp <= 1'b0;
      if (int_en)
        int_oe_o <= 1'b1;
      int_o <= int_oe_o && (pend_field || pend_temp);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; write-only and unmapped offsets read zero
  always_comb
  begin
    next_rdata = meas_pkg::READ_IDLE;
    unique case (reg_addr_i)
      meas_pkg::ADDR_X_HIGH: next_rdata = x_result[17:10];
      meas_pkg::ADDR_X_MID: next_rdata = x_result[9:2];
      meas_pkg::ADDR_Y_HIGH: next_rdata = y_result[17:10];
      meas_pkg::ADDR_Y_MID: next_rdata = y_result[9:2];
      meas_pkg::ADDR_Z_HIGH: next_rdata = z_result[17:10];
      meas_pkg::ADDR_Z_MID: next_rdata = z_result[9:2];
      meas_pkg::ADDR_XYZ_LOW:
        next_rdata = {x_result[1:0], y_result[1:0], z_result[1:0], 2'h0};
      meas_pkg::ADDR_TEMP: next_rdata = temp_result;
      meas_pkg::ADDR_STATUS:
      begin
        next_rdata = meas_pkg::STATUS_RESET;
        next_rdata[meas_pkg::STAT_FIELD_DONE] = field_done;
        next_rdata[meas_pkg::STAT_TEMP_DONE] = temp_done;
        next_rdata[meas_pkg::STAT_TRIM_OK] = trim_ok;
      end
      default: next_rdata = meas_pkg::READ_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      reg_rdata_o <= meas_pkg::READ_IDLE;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
        reg_rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timing sub-blocks
  coil_pulse_gen u_pulse
  (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .start_i(pulse_start),
    .polarity_i(pulse_polarity),
    .set_coil_o(set_coil_o),
    .reset_coil_o(reset_coil_o),
    .done_o(pulse_done)
  );

  conv_timer u_conv
  (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .start_i(conv_start),
    .length_i(conv_length),
    .busy_o(),
    .done_o(conv_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  chk_field_cmd_drop: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    ctl_wr && reg_wdata_i[0] && !field_end |=> !field_done)
    else $error("field done not dropped on command");
  chk_field_end: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    field_end && !ctl_wr |=> field_done && !start_field_conv)
    else $error("field end did not set done and clear start");
  chk_temp_end: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    temp_end && !ctl_wr |=> temp_done && !start_temp_conv)
    else $error("temp end did not set done and clear start");
  chk_int_clear: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    stat_wr && (reg_wdata_i[0] || !pend_field) && !conv_done
    && (reg_wdata_i[1] || !pend_temp) |=> ##1 !int_o)
    else $error("interrupt not cleared by status write");
  chk_int_raise: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    conv_done && int_en && int_oe_o |=> ##1 int_o)
    else $error("completion did not raise interrupt");
  chk_pin_undriven: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    !int_oe_o |-> !int_o)
    else $error("interrupt high while pin undriven");
  chk_low_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    reg_rd_i && reg_addr_i == meas_pkg::ADDR_XYZ_LOW
    |=> reg_rdata_o[1:0] == 2'h0 && reg_rdata_o[7:6] == $past(x_result[1:0]))
    else $error("low bits register wrong");
  chk_trim_flag: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    state == meas_pkg::ST_TRIM && trim_done_i |=> trim_ok && !trim_reload)
    else $error("trim load not reported");

endmodule : magnetometer_meas_ctrl_regs

`default_nettype wire

// ---- verif/sensor_front_model.sv ----
/*
  front-end model: fixed axis and temperature codes, and a trim memory
  that answers each load request a few cycles later.
  assumes the single 20 MHz system clock of the block.
*/
`timescale 1ns/1ps
`default_nettype none

module sensor_front_model
#(
  parameter logic [17:0] X_VAL = 18'h2A5C3,
  parameter logic [17:0] Y_VAL = 18'h1F00E,
  parameter logic [17:0] Z_VAL = 18'h0C3B5,
  parameter logic [7:0] T_VAL = 8'h9D
)
(
  // clock
  input wire logic sys_clk_i,
  // trim memory
  input wire logic trim_load_i,
  output logic trim_done_o,
  // converter results
  output logic [17:0] x_field_o,
  output logic [17:0] y_field_o,
  output logic [17:0] z_field_o,
  output logic [7:0] temp_code_o
);
  logic [3:0] wait_cnt = 4'h0;

  // codes held still so any capture cycle gives the same value
  assign x_field_o = X_VAL;
  assign y_field_o = Y_VAL;
  assign z_field_o = Z_VAL;
  assign temp_code_o = T_VAL;
  assign trim_done_o = (wait_cnt == 4'h1);

  // trim answers late on purpose, never in the request cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (trim_load_i)
      wait_cnt <= 4'h6;
    else if (wait_cnt != 4'h0)
      wait_cnt <= wait_cnt - 4'h1;
  end
endmodule : sensor_front_model

`default_nettype wire

// ---- verif/magnetometer_meas_ctrl_regs_tb_top.sv ----
/*
  bench: boot, field and temperature conversions, coil pulses, trim.
  assumes the package, design and front-end model compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module magnetometer_meas_ctrl_regs_tb_top;
  localparam logic [17:0] XV = 18'h2A5C3;
  localparam logic [17:0] YV = 18'h1F00E;
  localparam logic [17:0] ZV = 18'h0C3B5;
  localparam logic [7:0] TV = 8'h9D;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [1:0] conv_length_sel_i = 2'h0;
  logic [7:0] reg_rdata_o;
  logic reg_rvalid_o, field_conv_o, temp_conv_o, set_coil_o, reset_coil_o;
  logic trim_load_o, trim_done_i, int_o, int_oe_o;
  logic [17:0] x_field_i, y_field_i, z_field_i;
  logic [7:0] temp_code_i;
  int checks = 0;
  int fails = 0;
  int cycles = 0;
  int f_len = 0;
  int t_len = 0;
  int s_len = 0;
  int r_len = 0;
  int l_cnt = 0;

  magnetometer_meas_ctrl_regs #(.CONV_SEL0_CYC(40), .CONV_SEL1_CYC(30),
    .CONV_SEL2_CYC(20), .CONV_SEL3_CYC(10), .CONV_TEMP_CYC(25))
  magnetometer_meas_ctrl_regs_i (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .conv_length_sel_i(conv_length_sel_i), .x_field_i(x_field_i),
    .y_field_i(y_field_i), .z_field_i(z_field_i),
    .temp_code_i(temp_code_i), .field_conv_o(field_conv_o),
    .temp_conv_o(temp_conv_o), .set_coil_o(set_coil_o),
    .reset_coil_o(reset_coil_o), .trim_load_o(trim_load_o),
    .trim_done_i(trim_done_i), .int_o(int_o), .int_oe_o(int_oe_o));

  sensor_front_model #(.X_VAL(XV), .Y_VAL(YV), .Z_VAL(ZV), .T_VAL(TV))
  sensor_front_model_i (.sys_clk_i(sys_clk_i), .trim_load_i(trim_load_o),
    .trim_done_o(trim_done_i), .x_field_o(x_field_i),
    .y_field_o(y_field_i), .z_field_o(z_field_i),
    .temp_code_o(temp_code_i));

  always #25 sys_clk_i = ~sys_clk_i;

  // widths tallied per edge; the cycle ceiling cuts a hang short
  always @(posedge sys_clk_i)
  begin
    f_len += int'(field_conv_o);
    t_len += int'(temp_conv_o);
    s_len += int'(set_coil_o);
    r_len += int'(reset_coil_o);
    l_cnt += int'(trim_load_o);
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic cyc();
    @(posedge sys_clk_i);
    #1;
  endtask : cyc

  task automatic chk(input string what, input logic [7:0] exp, got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // strobes drop and one idle edge follows, so calls never collide
  task automatic wr(input logic [7:0] a, d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    cyc();
    reg_wr_i = 1'b0;
    cyc();
  endtask : wr

  task automatic rd(input logic [7:0] a, exp, input string what);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    cyc();
    reg_rd_i = 1'b0;
    chk("read valid", 8'h01, {7'h00, reg_rvalid_o});
    chk(what, exp, reg_rdata_o);
    cyc();
  endtask : rd

  task automatic wait_int();
    for (int n = 0; n < 400 && int_o !== 1'b1; n++)
      cyc();
    chk("int pin", 8'h03, {6'h00, int_oe_o, int_o});
  endtask : wait_int

  task automatic clear_int(input logic [7:0] d);
    wr(8'h08, d);
    cyc();
    chk("int cleared", 8'h00, {7'h00, int_o});
  endtask : clear_int

  task automatic t_boot();
    rd(8'h08, 8'h00, "status at reset");
    rd(8'h09, 8'h00, "control read");
    chk("pin idle", 8'h00, {6'h00, int_oe_o, int_o});
    repeat (12) cyc();
    rd(8'h08, 8'h10, "trim loaded");
  endtask : t_boot

  task automatic t_field(input logic [1:0] sel, input logic [7:0] len);
    conv_length_sel_i = sel;
    f_len = 0;
    wr(8'h09, 8'h05);
    rd(8'h08, 8'h10, "field running");
    wait_int();
    chk("field length", len, 8'(f_len));
    rd(8'h08, 8'h11, "field done");
    chk("field stopped", 8'h00, {7'h00, field_conv_o});
    clear_int(8'h01);
  endtask : t_field

  task automatic t_results();
    rd(8'h00, XV[17:10], "x high");
    rd(8'h01, XV[9:2], "x mid");
    rd(8'h02, YV[17:10], "y high");
    rd(8'h03, YV[9:2], "y mid");
    rd(8'h04, ZV[17:10], "z high");
    rd(8'h05, ZV[9:2], "z mid");
    rd(8'h06, {XV[1:0], YV[1:0], ZV[1:0], 2'h0}, "low bits");
    rd(8'h0F, 8'h00, "unmapped");
  endtask : t_results

  task automatic t_auto();
    s_len = 0;
    wr(8'h09, 8'h25);
    wait_int();
    chk("auto set width", 8'h0A, 8'(s_len));
    clear_int(8'h01);
  endtask : t_auto

  task automatic t_temp();
    t_len = 0;
    wr(8'h09, 8'h06);
    rd(8'h08, 8'h11, "temp running");
    wait_int();
    chk("temp length", 8'h19, 8'(t_len));
    rd(8'h08, 8'h13, "temp done");
    rd(8'h07, TV, "temp code");
    clear_int(8'h02);
  endtask : t_temp

  task automatic t_coils();
    s_len = 0;
    r_len = 0;
    l_cnt = 0;
    wr(8'h09, 8'h1C);
    repeat (40) cyc();
    chk("set width", 8'h0A, 8'(s_len));
    chk("reset width", 8'h0A, 8'(r_len));
    wr(8'h09, 8'h44);
    repeat (20) cyc();
    chk("trim requests", 8'h01, 8'(l_cnt));
    rd(8'h08, 8'h13, "status kept");
  endtask : t_coils

  // main sequence; results are read again last to show they held
  initial
  begin
    repeat (5) cyc();
    resetn_i = 1'b1;
    t_boot();
    t_field(2'h0, 8'h28);
    t_results();
    t_field(2'h1, 8'h1E);
    t_field(2'h2, 8'h14);
    t_field(2'h3, 8'h0A);
    t_auto();
    t_temp();
    t_coils();
    t_results();
    conclude();
  end
endmodule : magnetometer_meas_ctrl_regs_tb_top

`default_nettype wire
